// ### rtl/supervisor_pkg.sv
package supervisor_pkg;

    // ------------------------------------------------------------------
    // Timing figures and derived cycle and tick counts
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int WATCHDOG_MS = 1600;
    localparam int RELEASE_MS = 200;
    localparam int DEBOUNCE_US = 10;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int WATCHDOG_TICKS = WATCHDOG_MS * 1000;
    localparam int RELEASE_TICKS = RELEASE_MS * 1000;
    localparam int DEBOUNCE_TICKS = DEBOUNCE_US * 1000 / TICK_NS;
    localparam int PAGE_BYTES = 16;
    localparam int CNT_W = 21;

endpackage : supervisor_pkg

// ### rtl/supply_supervisor_watchdog.sv
// How it works
// RULE_01 - No kick activity for the watchdog interval forces a full reset.
// RULE_02 - Supply below trip level asserts both reset outputs at once.
// RULE_03 - After supply recovers, reset is held for the release delay.
// RULE_04 - Two reset outputs carry one condition, one high, one low.
// RULE_05 - A reset pin doubles as push-button input and is debounced.
// RULE_06 - Both reset pins are open-drain: driven out and sensed back.
// RULE_07 - Memory writes are inhibited while supply is below trip level.
// RULE_08 - Write-protect input blocks array writes independently of supply.
// RULE_09 - Write path buffers one page of sixteen bytes before programming.
// RULE_10 - Any kick input edge clears the watchdog timer.
// RULE_11 - Watchdog timer holds cleared while reset is asserted.
// RULE_12 - Forced reset is edge detected and starts a full release timeout.
// RULE_13 - Memory accesses are refused while either reset is active.
// RULE_14 - Timeouts are counters on a free-running internal time base.
`timescale 1ns/1ps
`default_nettype none

module supply_supervisor_watchdog
    import supervisor_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES,
    parameter int WD_TICKS = WATCHDOG_TICKS,
    parameter int REL_TICKS = RELEASE_TICKS,
    parameter int DB_TICKS = DEBOUNCE_TICKS,
    parameter int PAGE = PAGE_BYTES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic supplyOk,
    input wire logic watchdog_kick_input,
    input wire logic writeProtect,
    input wire logic resetLowIn,
    input wire logic resetHighIn,
    input wire logic accessReq,
    input wire logic byteValid,
    input wire logic [7:0] byteData,
    input wire logic pageCommit,
    output logic resetLowOut,
    output logic resetLowOe_n,
    output logic resetHighOut,
    output logic resetHighOe_n,
    output logic accessAck,
    output logic writeAllowed,
    output logic programStrobe,
    output logic [4:0] programCount,
    output logic [7:0] pageByte0
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (TICK_DIV < 1 || TICK_DIV > 1024 || WD_TICKS < 2 || REL_TICKS < 2
        || WD_TICKS >= (1 << CNT_W) || REL_TICKS >= (1 << CNT_W)
        || DB_TICKS < 1 || DB_TICKS > 255 || PAGE != 16) begin : g_bad
        $error("supply_supervisor_watchdog: parameter out of range");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] supSync;
        logic [1:0] kickSync;
        logic [1:0] wpSync;
        logic [1:0] lowSync;
        logic [1:0] highSync;
        logic kickPrev;
        logic lowDb;
        logic highDb;
        logic [7:0] lowCnt;
        logic [7:0] highCnt;
        logic [9:0] divCnt;
        logic tick;
        logic [CNT_W-1:0] wdCnt;
        logic [CNT_W-1:0] relCnt;
        logic inReset;
        logic oeN;
        logic [4:0] fill;
        logic [4:0] progCnt;
        logic progStb;
        logic ack;
        logic wrOk;
        logic [7:0] byte0;
    } state_type;

    state_type s_r;
    state_type s_nxt;
    logic [7:0] page [0:15];

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Supply, kick, protect and reset pins pass two flops; only the second stage feeds logic.
    always_comb begin
        logic kick;
        logic lowFall;
        logic highRise;
        logic supNow;
        logic startRel;
        kick = 1'b0;
        lowFall = 1'b0;
        highRise = 1'b0;
        supNow = 1'b0;
        startRel = 1'b0;
        s_nxt = s_r;
        s_nxt.supSync = {s_r.supSync[0], supplyOk};
        s_nxt.kickSync = {s_r.kickSync[0], watchdog_kick_input};
        s_nxt.wpSync = {s_r.wpSync[0], writeProtect};
        // The pin we drive reads back asserted; its edges only count while released.
        s_nxt.lowSync = {s_r.lowSync[0], resetLowIn};
        s_nxt.highSync = {s_r.highSync[0], resetHighIn};
        s_nxt.kickPrev = s_r.kickSync[1];
        supNow = s_r.supSync[1];
        kick = s_r.kickSync[1] ^ s_r.kickPrev; // see RULE_10
        s_nxt.progStb = 1'b0;

        // Free-running microsecond time base.
        s_nxt.tick = 1'b0; // see RULE_14
        if (s_r.divCnt == 10'(TICK_DIV - 1)) begin
            s_nxt.divCnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.divCnt = s_r.divCnt + 10'd1;
        end

        // Debounce each sensed reset pin; a level must hold DB_TICKS ticks.
        if (s_r.lowSync[1] == s_r.lowDb) begin // see RULE_05
            s_nxt.lowCnt = '0;
        end else if (s_r.tick) begin
            if (s_r.lowCnt == 8'(DB_TICKS - 1)) begin
                s_nxt.lowDb = s_r.lowSync[1];
                s_nxt.lowCnt = '0;
                lowFall = !s_r.lowSync[1];
            end else begin
                s_nxt.lowCnt = s_r.lowCnt + 8'd1;
            end
        end
        if (s_r.highSync[1] == s_r.highDb) begin
            s_nxt.highCnt = '0;
        end else if (s_r.tick) begin
            if (s_r.highCnt == 8'(DB_TICKS - 1)) begin
                s_nxt.highDb = s_r.highSync[1];
                s_nxt.highCnt = '0;
                highRise = s_r.highSync[1];
            end else begin
                s_nxt.highCnt = s_r.highCnt + 8'd1;
            end
        end

        // Reset hold: any cause reloads the full release delay.
        startRel = (!s_r.inReset && (lowFall || highRise)) // see RULE_12
            || (!s_r.inReset && s_r.tick && s_r.wdCnt == CNT_W'(WD_TICKS - 1)); // see RULE_01
        if (!supNow) begin // see RULE_02
            s_nxt.inReset = 1'b1;
            s_nxt.relCnt = '0;
        end else if (startRel) begin
            s_nxt.inReset = 1'b1;
            s_nxt.relCnt = '0;
        end else if (s_r.inReset && s_r.tick) begin
            if (s_r.relCnt == CNT_W'(REL_TICKS - 1)) begin // see RULE_03
                s_nxt.inReset = 1'b0;
                s_nxt.relCnt = '0;
            end else begin
                s_nxt.relCnt = s_r.relCnt + CNT_W'(1);
            end
        end

        // Pin enables get their own flop so the pins never see a decode glitch.
        s_nxt.oeN = !s_nxt.inReset; // see RULE_04

        // Watchdog counts ticks, cleared by kicks and held during reset.
        if (s_r.inReset || kick || startRel) begin // see RULE_11
            s_nxt.wdCnt = '0;
        end else if (s_r.tick) begin
            s_nxt.wdCnt = s_r.wdCnt + CNT_W'(1);
        end

        // Access and write gating.
        s_nxt.ack = accessReq && !s_nxt.inReset; // see RULE_13
        s_nxt.wrOk = supNow && !s_r.wpSync[1]; // see RULE_07 see RULE_08

        // Page buffer: bytes collect, commit programs the collected page.
        if (byteValid && s_r.ack && s_r.fill < 5'(PAGE)) begin // see RULE_09
            s_nxt.fill = s_r.fill + 5'd1;
        end
        if (pageCommit) begin
            s_nxt.fill = '0;
            if (s_r.wrOk && s_r.ack && s_r.fill != '0) begin
                s_nxt.progStb = 1'b1;
                s_nxt.progCnt = s_r.fill;
                s_nxt.byte0 = page[0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Reset releases with the reset pins asserted and writes blocked.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
            s_r.inReset <= 1'b1;
            s_r.lowDb <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Page storage needs no reset; fill count guards its contents.
    always_ff @(posedge clk) begin
        if (byteValid && s_r.ack && s_r.fill < 5'(PAGE)) begin
            page[s_r.fill[3:0]] <= byteData;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Open drain: enable low while asserting, data is the asserted level.
    assign resetLowOut = 1'b0; // see RULE_04 see RULE_06
    assign resetHighOut = 1'b1;
    assign resetLowOe_n = s_r.oeN;
    assign resetHighOe_n = s_r.oeN;
    assign accessAck = s_r.ack;
    assign writeAllowed = s_r.wrOk;
    assign programStrobe = s_r.progStb;
    assign programCount = s_r.progCnt;
    assign pageByte0 = s_r.byte0;

endmodule : supply_supervisor_watchdog

`default_nettype wire

// ### sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic kickEn,
    input wire logic press,
    input wire logic resetLowOe_n,
    input wire logic resetHighOe_n,
    output logic kick,
    output logic resetLowIn,
    output logic resetHighIn
);
    logic [4:0] gap = 5'h00;
    logic kickLvl = 1'b0;
    // Toggle every 20 cycles, well inside the watchdog interval.
    always @(posedge clk) begin
        gap <= (gap == 5'h13) ? 5'h00 : gap + 5'h01;
        kickLvl <= (kickEn && gap == 5'h13) ? ~kickLvl : kickLvl;
    end
    assign kick = kickLvl;
    // Pull-up on the low line, pull-down on the high one; the button pulls low.
    assign resetLowIn = !resetLowOe_n || press ? 1'b0 : 1'b1;
    assign resetHighIn = !resetHighOe_n;
endmodule : host_model
`default_nettype wire

// ### sim/supervisor_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_checker #(parameter int TICK_DIV = 2, parameter int WD_TICKS = 50,
    parameter int REL_TICKS = 30) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic supplyOk,
    input wire logic watchdog_kick_input,
    input wire logic writeProtect,
    input wire logic pageCommit,
    input wire logic resetLowOe_n,
    input wire logic resetHighOe_n,
    input wire logic accessAck,
    input wire logic writeAllowed,
    input wire logic programStrobe,
    input wire logic [4:0] programCount
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    int heldCnt_r;
    int idleCnt_r;
    // Cycles spent in reset, and released cycles since the last kick edge.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            heldCnt_r <= 0;
            idleCnt_r <= 0;
        end else begin
            heldCnt_r <= resetLowOe_n ? 0 : heldCnt_r + 1;
            idleCnt_r <= (!resetLowOe_n || $changed(watchdog_kick_input)) ? 0 : idleCnt_r + 1;
        end
    end
    property p_pair; resetLowOe_n == resetHighOe_n; endproperty
    a_pair: assert property (p_pair) else $error("outputs disagree");
    property p_sup; !supplyOk [*4] |-> !resetLowOe_n && !writeAllowed; endproperty
    a_sup: assert property (p_sup) else $error("supply lockout");
    property p_hold; $rose(resetLowOe_n) |-> heldCnt_r >= REL_TICKS * TICK_DIV - TICK_DIV - 1; endproperty
    a_hold: assert property (p_hold) else $error("release early");
    // The margin covers input sync and one tick of jitter.
    property p_dog; idleCnt_r <= WD_TICKS * TICK_DIV + 12; endproperty
    a_dog: assert property (p_dog) else $error("watchdog late");
    property p_deaf; !resetLowOe_n |-> !accessAck; endproperty
    a_deaf: assert property (p_deaf) else $error("ack in reset");
    property p_wp; writeProtect [*4] |-> !writeAllowed; endproperty
    a_wp: assert property (p_wp) else $error("protect ignored");
    property p_lock; pageCommit && !writeAllowed |=> !programStrobe; endproperty
    a_lock: assert property (p_lock) else $error("locked write");
    property p_page; programStrobe |-> $past(pageCommit) && programCount inside {[1:16]}; endproperty
    a_page: assert property (p_page) else $error("bad page");
endmodule : supervisor_checker
bind supply_supervisor_watchdog supervisor_checker #(.TICK_DIV(TICK_DIV),
    .WD_TICKS(WD_TICKS), .REL_TICKS(REL_TICKS)) watch (.clk(clk), .arst_n(arst_n),
    .supplyOk(supplyOk), .watchdog_kick_input(watchdog_kick_input),
    .writeProtect(writeProtect), .pageCommit(pageCommit), .resetLowOe_n(resetLowOe_n),
    .resetHighOe_n(resetHighOe_n), .accessAck(accessAck), .writeAllowed(writeAllowed),
    .programStrobe(programStrobe), .programCount(programCount));
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int REL = 60;
    logic clk = 1'b0, arst_n = 1'b0, supplyOk = 1'b1, writeProtect = 1'b0, accessReq = 1'b0;
    logic byteValid = 1'b0, pageCommit = 1'b0, kickEn = 1'b1, press = 1'b0;
    logic [7:0] byteData = 8'h00;
    logic kick, lowIn, highIn, lowOut, lowOe_n, highOut, highOe_n, accessAck, writeOk, strobe;
    logic [4:0] progCnt;
    logic [7:0] byte0;
    int failures = 0, comparisons = 0, n;
    supply_supervisor_watchdog #(.TICK_DIV(2), .WD_TICKS(50), .REL_TICKS(30), .DB_TICKS(2)) dut (
        .clk(clk), .arst_n(arst_n), .supplyOk(supplyOk), .watchdog_kick_input(kick),
        .writeProtect(writeProtect), .resetLowIn(lowIn), .resetHighIn(highIn),
        .accessReq(accessReq), .byteValid(byteValid), .byteData(byteData),
        .pageCommit(pageCommit), .resetLowOut(lowOut), .resetLowOe_n(lowOe_n),
        .resetHighOut(highOut), .resetHighOe_n(highOe_n), .accessAck(accessAck),
        .writeAllowed(writeOk), .programStrobe(strobe), .programCount(progCnt), .pageByte0(byte0));
    host_model host (.clk(clk), .kickEn(kickEn), .press(press), .resetLowOe_n(lowOe_n),
        .resetHighOe_n(highOe_n), .kick(kick), .resetLowIn(lowIn), .resetHighIn(highIn));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Counts edges until the low reset enable reaches lvl; the caller judges the count.
    task automatic waitRst(input logic lvl, input int lim);
        n = 0;
        while (lowOe_n !== lvl && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : waitRst
    // Streams cnt bytes; more than a page must be clipped to sixteen.
    task automatic t_page(input logic wp, input int cnt);
        @(posedge clk);
        writeProtect <= wp;
        accessReq <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk({accessAck, writeOk}, {1'b1, !wp});
        for (int i = 0; i < cnt; i++) begin
            @(posedge clk);
            byteValid <= 1'b1;
            byteData <= 8'(8'h40 + i);
        end
        @(posedge clk);
        byteValid <= 1'b0;
        pageCommit <= 1'b1;
        @(posedge clk);
        pageCommit <= 1'b0;
        writeProtect <= 1'b0;
        // The strobe stands for this one cycle only.
        #1;
        chk({strobe, progCnt, byte0 == 8'h40}, {!wp, 5'h10, 1'b1});
    endtask : t_page
    task automatic t_dog;
        repeat (300) @(posedge clk);
        kickEn <= 1'b0;
        #1;
        chk(lowOe_n, 1'b1);
        waitRst(1'b0, 140);
        chk(n >= 80 && n <= 112, 1'b1);
        waitRst(1'b1, 100);
        repeat (40) @(posedge clk);
        kickEn <= 1'b1;
        #1;
        chk(lowOe_n, 1'b1);
    endtask : t_dog
    // A one-cycle bounce must be ignored; a held press starts a full timeout.
    task automatic t_button;
        @(posedge clk);
        press <= 1'b1;
        @(posedge clk);
        press <= 1'b0;
        repeat (20) @(posedge clk);
        press <= 1'b1;
        #1;
        chk(lowOe_n, 1'b1);
        waitRst(1'b0, 30);
        chk(n >= 4 && n <= 14, 1'b1);
        @(posedge clk);
        press <= 1'b0;
        #1;
        chk({accessAck, highOe_n}, 8'h00);
        waitRst(1'b1, 100);
        chk(n >= REL - 8 && n <= REL + 4, 1'b1);
    endtask : t_button
    task automatic t_brown;
        @(posedge clk);
        supplyOk <= 1'b0;
        repeat (50) @(posedge clk);
        supplyOk <= 1'b1;
        #1;
        chk({lowOe_n, highOe_n, writeOk}, 8'h00);
        waitRst(1'b1, 100);
        chk(n >= REL - 2 && n <= REL + 6, 1'b1);
    endtask : t_brown
    task automatic report_and_stop;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    // The run needs about 800 cycles; far beyond that something hangs.
    initial begin
        #50000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk({lowOe_n, highOe_n, lowOut, highOut}, 8'h01);
        waitRst(1'b1, 200);
        chk(n >= REL && n <= REL + 8, 1'b1);
        t_page(1'b0, 18);
        t_page(1'b1, 3);
        t_dog();
        t_button();
        t_brown();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
